// ==== dv/rxd_core_properties.sv ====
// checker for the expansion core: pin-level timing relations
// assumes i_ce drops only while the sdram side idles, and a bench-driven sequencer
`timescale 1ns/10ps
`default_nettype none
module rxd_core_properties (
   input wire logic                i_ref_clk,
   input wire logic                i_srst,
   input wire logic                i_phi2,
   input wire rxd_pkg::rxd_seq_t   i_seq,
   input wire logic [15:0]         o_host_addr,
   input wire logic                o_host_addr_oe_n,
   input wire logic                o_host_data_oe_n,
   input wire logic                o_buf_dir,
   input wire logic                o_dma_n,
   input wire logic                o_irq,
   input wire logic                o_sdram_clk,
   input wire rxd_pkg::rxd_sdram_t o_sdram,
   input wire logic                o_sdram_dq_oe_n
);
   import rxd_pkg::*;
   // one domain, so clock and reset are given once
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   chk_sdram_clk_inv: assert property (o_sdram_clk == !i_ref_clk)
      else $error("sdram clock is not the inverted dot clock");
   // row opens only where phase-2 was low two samples earlier
   chk_act_in_low: assert property (o_sdram.cmd == CMD_ACT |-> !$past(i_phi2, 2))
      else $error("row opened outside phase-2 low");
   chk_act_then_rw: assert property (o_sdram.cmd == CMD_ACT |=>
      o_sdram.cmd inside {CMD_RD, CMD_WR})
      else $error("activate not followed by the access");
   // refresh belongs to the high half only
   chk_refresh_high: assert property (o_sdram.cmd == CMD_REF |-> $past(i_phi2, 2))
      else $error("refresh outside phase-2 high");
   chk_wr_drives_dq: assert property ((o_sdram.cmd == CMD_WR) == !o_sdram_dq_oe_n)
      else $error("sdram data drive not aligned with write");
   // during dma, outside an autoload, the host address only ever steps
   chk_host_addr_step: assert property (i_seq.dma && !$past(i_seq.transfer_done) && $changed(o_host_addr) |->
      o_host_addr == $past(o_host_addr) + 16'h0001)
      else $error("host address moved by other than one");
   chk_addr_drive: assert property (o_host_addr_oe_n == !i_seq.dma)
      else $error("host address drive not tied to dma");
   chk_glue_pins: assert property (o_dma_n == !i_seq.dma && o_buf_dir == !o_host_data_oe_n)
      else $error("bus glue outputs inconsistent");
   // an interrupt has a transfer end as its only cause here
   chk_irq_cause: assert property ($rose(o_irq) |->
      $past(i_seq.transfer_done) || $past(i_seq.transfer_done, 2))
      else $error("interrupt without transfer end");
endmodule : rxd_core_properties
bind rxd_core rxd_core_properties u_chk (.i_ref_clk, .i_srst, .i_phi2, .i_seq, .o_host_addr,
   .o_host_addr_oe_n, .o_host_data_oe_n, .o_buf_dir, .o_dma_n, .o_irq, .o_sdram_clk, .o_sdram,
   .o_sdram_dq_oe_n);
`default_nettype wire

// ==== dv/rxd_sdram_model.sv ====
// sdram stand-in: byte memory decoded from bank, row and column commands
// assumes commands are taken on the inverted dot clock, read latency two
`timescale 1ns/10ps
`default_nettype none
module rxd_sdram_model (
   input  wire logic                i_clk,
   input  wire rxd_pkg::rxd_sdram_t i_bus,
   input  wire logic [7:0]          i_dq,
   output logic [7:0]               o_dq,
   output logic [25:0]              o_wr_addr
);
   import rxd_pkg::*;
   logic [7:0]  mem_q [int];   // sparse byte store
   logic [12:0] row_q [4];     // open row per bank
   logic [7:0]  rd_q  [2];     // read pipe
   logic [1:0]  vld_q;         // read pipe valid
   logic [25:0] adr;           // full byte address
   initial begin
      o_dq = 8'h00;
      o_wr_addr = '0;
      vld_q = '0;
      foreach (row_q[i]) row_q[i] = '0;
   end
   // commands sampled on the sdram clock, never on the dot clock
   always @(posedge i_clk) begin
      adr = {i_bus.ba, row_q[i_bus.ba], i_bus.a[11], i_bus.a[9:0]};
      if (i_bus.cmd == CMD_ACT) row_q[i_bus.ba] <= i_bus.a;
      if (i_bus.cmd == CMD_WR) begin
         mem_q[adr] = i_dq;
         o_wr_addr <= adr;
      end
      rd_q[0] <= mem_q.exists(adr) ? mem_q[adr] : 8'h3C;
      rd_q[1] <= rd_q[0];
      vld_q <= {vld_q[0], i_bus.cmd == CMD_RD};
      // off the data window the pins toggle, so a stale byte never holds for two cycles in a row
      o_dq <= vld_q[1] ? rd_q[1] : ~o_dq;
   end
endmodule : rxd_sdram_model
`default_nettype wire

// ==== dv/test_ram_expansion_dma_core.sv ====
// self-checking bench for the expansion core with an sdram stand-in
// assumes a 10 MHz dot clock and a free-running 800 ns host phase-2
`timescale 1ns/10ps
`default_nettype none
module test_ram_expansion_dma_core;
   import rxd_pkg::*;
   logic        clk = 0;      // dot clock
   logic        srst = 1;     // sync reset
   logic        ce = 1;       // clock enable
   logic        cke;          // sdram clock enable
   logic        phi2 = 0;     // host phase-2
   logic        ba = 1;       // host bus available
   logic        rw = 1;       // host read when high
   logic        sel_n = 1;    // register window select
   logic [15:0] haddr = '0;   // host address in
   logic [7:0]  hdata = '0;   // host data in
   rxd_seq_t    seq = '0;     // sequencer strobes
   rxd_stat_t   stat;         // core status
   logic [15:0] oaddr;        // host address out
   logic [7:0]  odata;        // host data out
   logic        irq;          // interrupt
   logic        sclk;         // sdram clock
   rxd_sdram_t  sbus;         // sdram command bus
   logic [7:0]  sdq_m;        // model data out
   logic [7:0]  sdq_c;        // core data out
   logic        sdq_oe_n;     // core drives sdram data
   logic [25:0] wr_addr;      // last sdram write address
   logic [7:0]  rd;           // register byte seen
   logic [7:0]  snap;         // host data at end of dma cycle
   int          n_errors = 0;
   int          check_count = 0;
   // shared data pins resolve from the core's enable
   wire logic [7:0] dq_w = !sdq_oe_n ? sdq_c : sdq_m;
   always #50 clk = ~clk;
   // phase-2 runs free, off the dot clock's edges
   initial #130 forever #400 phi2 = ~phi2;
   rxd_core uut (.i_ref_clk(clk), .i_srst(srst), .i_ce(ce), .i_phi2(phi2), .i_ba(ba),
      .i_host_rw(rw), .i_host_io_sel_n(sel_n), .i_host_addr(haddr), .i_host_data(hdata),
      .i_seq(seq), .o_stat(stat), .o_host_addr(oaddr), .o_host_addr_oe_n(), .o_host_data(odata),
      .o_host_data_oe_n(), .o_buf_dir(), .o_dma_n(), .o_irq(irq), .o_sdram_clk(sclk),
      .o_sdram_cke(cke), .o_sdram(sbus), .i_sdram_dq(dq_w), .o_sdram_dq(sdq_c),
      .o_sdram_dq_oe_n(sdq_oe_n));
   rxd_sdram_model u_ram (.i_clk(sclk), .i_bus(sbus), .i_dq(dq_w), .o_dq(sdq_m),
      .o_wr_addr(wr_addr));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   // one register access per two phase-2 periods; read byte taken before the fall
   task automatic reg_io(input logic w, input logic [4:0] off, input logic [7:0] d);
      @(posedge phi2);
      @(posedge clk);
      #1;
      sel_n = 0;
      rw = !w;
      haddr = {11'h000, off};
      hdata = d;
      @(negedge phi2);
      rd = odata;
      @(posedge phi2);
      @(posedge clk);
      #1;
      sel_n = 1;
      rw = 1;
      hdata = ~d;
   endtask : reg_io
   // strobes held over one fall; dma kept until the read byte has landed
   task automatic dma_cycle(input rxd_seq_t s);
      @(posedge phi2);
      @(posedge clk);
      #1;
      seq = s;
      @(posedge phi2);
      @(posedge clk);
      #1;
      seq = '{dma: s.dma, default: 0};
      repeat (5) @(posedge clk);
      #1;
      snap = odata;
      seq = '0;
   endtask : dma_cycle
   task automatic t_reset;
      chk("irq", 32'h0, irq);
      chk("sdram cmd", CMD_NOP, sbus.cmd);
      chk("busy in init", 32'h1, stat.ram_busy);
      chk("sdram cke", 32'h1, cke);
      reg_io(0, 5'h08, 8'h00);
      chk("len lo", 8'hFF, rd);
      reg_io(0, 5'h09, 8'h00);
      chk("len hi", 8'hFF, rd);
      // sdram requests are honoured only after the init wait
      repeat (1010) @(posedge clk);
      #1;
   endtask : t_reset
   task automatic t_regs;
      reg_io(1, 5'h02, 8'h34);
      reg_io(1, 5'h03, 8'h12);
      chk("host addr", 16'h1234, oaddr);
      reg_io(0, 5'h03, 8'h00);
      chk("host addr hi", 8'h12, rd);
      reg_io(1, 5'h0C, 8'h77);
      reg_io(0, 5'h0C, 8'h00);
      chk("unmapped", 8'h00, rd);
      // carry across every byte of the expansion address
      foreach (haddr[i]) if (i < 4) reg_io(1, 5'h04 + i[4:0], (i < 3) ? 8'hFF : 8'h00);
   endtask : t_regs
   task automatic t_dma;
      dma_cycle('{dma: 1, expansion_addr_advance: 1, host_addr_advance: 1, default: 0});
      chk("host addr step", 16'h1235, oaddr);
      ba = 0;
      dma_cycle('{dma: 1, expansion_addr_advance: 1, host_addr_advance: 1, default: 0});
      chk("host addr held", 16'h1235, oaddr);
      ba = 1;
      hdata = 8'h5A;
      dma_cycle('{dma: 1, ram_req: 1, ram_we: 1, default: 0});
      chk("write addr", 26'h1000000, wr_addr);
      dma_cycle('{dma: 1, ram_req: 1, default: 0});
      chk("dma data", 8'h5A, snap);
      chk("match", 1'b1, stat.match);
      hdata = 8'hA5;
      repeat (4) @(posedge clk);
      #1;
      chk("no match", 1'b0, stat.match);
   endtask : t_dma
   task automatic t_irq;
      logic [7:0] mask [4] = '{8'hC0, 8'hA0, 8'hA0, 8'h00};
      logic [3:0] mism = 4'hC;
      logic [3:0] want = 4'h5;
      for (int i = 0; i < 4; i++) begin
         reg_io(1, 5'h0A, mask[i]);
         dma_cycle('{dma: 1, transfer_done: 1, compare_mismatch: mism[i], default: 0});
         chk("irq set", want[i], irq);
         reg_io(0, 5'h00, 8'h00);
         chk("status", mism[i] ? 8'h60 : 8'h40, rd & 8'h7F);
         chk("irq clear", 1'b0, irq);
      end
   endtask : t_irq
   task automatic t_len;
      reg_io(1, 5'h08, 8'h01);
      reg_io(1, 5'h09, 8'h00);
      chk("len one", 1'b1, stat.len_is_one);
      reg_io(1, 5'h08, 8'h02);
      chk("len two", 1'b0, stat.len_is_one);
      // start with autoload and type 1; the end strobe reloads the start values
      reg_io(1, 5'h01, 8'hA1);
      chk("exec set", 32'h1, stat.exec);
      chk("xfer type", 32'h1, stat.xfer_type);
      dma_cycle('{dma: 1, host_addr_advance: 1, transfer_done: 1, default: 0});
      chk("exec clear", 32'h0, stat.exec);
      chk("autoload", 16'h1234, oaddr);
      // length counts down to one and stops there
      dma_cycle('{dma: 1, expansion_addr_advance: 1, default: 0});
      chk("len counted", 32'h1, stat.len_is_one);
      dma_cycle('{dma: 1, expansion_addr_advance: 1, default: 0});
      chk("len held", 32'h1, stat.len_is_one);
      // fixed host address ignores its advance strobe
      reg_io(1, 5'h0B, 8'h80);
      dma_cycle('{dma: 1, host_addr_advance: 1, default: 0});
      chk("fixed host", 16'h1234, oaddr);
      // clock enable low: a whole register write passes unseen
      ce = 0;
      reg_io(1, 5'h02, 8'h99);
      ce = 1;
      chk("frozen", 16'h1234, oaddr);
   endtask : t_len
   initial begin
      repeat (20) @(posedge clk);
      #1;
      srst = 0;
      repeat (3) @(posedge clk);
      #1;
      t_reset;
      t_regs;
      t_dma;
      t_irq;
      t_len;
      tally_and_finish;
   end
   // watchdog well beyond the roughly 163 us the sequence needs
   initial begin
      #1000000;
      n_errors++;
      tally_and_finish;
   end
endmodule : test_ram_expansion_dma_core
`default_nettype wire

// ==== verilog/rxd_core.sv ====
// core of the ram expansion: sdram control, register block, datapath, glue
// assumes the dma sequencer is outside on i_ref_clk and the pins pass level shifters
`timescale 1ns/10ps
`default_nettype none
`include "rxd_defines.svh"
module rxd_core (
   input  wire logic              i_ref_clk,
   input  wire logic              i_srst,
   input  wire logic              i_ce,
   input  wire logic              i_phi2,
   input  wire logic              i_ba,
   input  wire logic              i_host_rw,
   input  wire logic              i_host_io_sel_n,
   input  wire logic [15:0]       i_host_addr,
   input  wire logic [7:0]        i_host_data,
   input  wire rxd_pkg::rxd_seq_t i_seq,
   output rxd_pkg::rxd_stat_t     o_stat,
   output logic [15:0]            o_host_addr,
   output logic                   o_host_addr_oe_n,
   output logic [7:0]             o_host_data,
   output logic                   o_host_data_oe_n,
   output logic                   o_buf_dir,
   output logic                   o_dma_n,
   output logic                   o_irq,
   output logic                   o_sdram_clk,
   output logic                   o_sdram_cke,
   output rxd_pkg::rxd_sdram_t    o_sdram,
   input  wire logic [7:0]        i_sdram_dq,
   output logic [7:0]             o_sdram_dq,
   output logic                   o_sdram_dq_oe_n
);
   import rxd_pkg::*;

   localparam int SW = 28;               // width of the synchronised pin group

   logic [SW-1:0] sync1_q;               // first stage, read only by sync2
   logic [SW-1:0] sync2_q;               // stable copy of the host pins
   logic          phi2_s, ba_s, rw_s, sel_n_s;
   logic [15:0]   haddr_s;
   logic [7:0]    hdata_s;
   logic          phi2_d1_q;             // previous phi2 for edges
   logic          fall_p, rise_p;        // one-cycle edge pulses

   // two-flop capture of everything arriving from the host bus
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else if (i_ce) begin
         sync1_q <= {i_phi2, i_ba, i_host_rw, i_host_io_sel_n, i_host_addr, i_host_data};
         sync2_q <= sync1_q;
      end
   end
   assign {phi2_s, ba_s, rw_s, sel_n_s, haddr_s, hdata_s} = sync2_q;

   // phase-2 edges seen on the dot clock
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) phi2_d1_q <= 1'b0;
      else if (i_ce) phi2_d1_q <= phi2_s;
   end
   assign fall_p = phi2_d1_q & ~phi2_s;  // first dot edge with phi2 low
   assign rise_p = ~phi2_d1_q & phi2_s;

   // ----- sdram controller
   rxd_state_t    st_q;
   rxd_sdram_t    sd_q;
   logic [15:0]   cnt_q;                 // wait and init counter
   logic          rd_pend_q;             // read data still to land
   logic          we_q;                  // latched direction of the access
   logic [25:0]   acc_addr_q;            // captured expansion address
   logic [7:0]    rd_data_q;             // last byte read from sdram
   logic [7:0]    wr_data_q;
   logic          dq_oe_n_q;
   logic [25:0]   exp_addr_q;            // expansion_mem_addr

   // the sdram runs half a cycle ahead for hold margin and latency
   assign o_sdram_clk = ~i_ref_clk;
   assign o_sdram_cke = 1'b1;

   // access and refresh sequencing
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         st_q       <= S_INIT;
         sd_q       <= '{cmd: CMD_NOP, ba: 2'h0, a: 13'h0000};
         cnt_q      <= 16'(`RXD_INIT_CYC);
         rd_pend_q  <= 1'b0;
         we_q       <= 1'b0;
         acc_addr_q <= 26'h0000000;
         rd_data_q  <= 8'h00;
         wr_data_q  <= 8'h00;
         dq_oe_n_q  <= 1'b1;
      end else if (i_ce) begin
         sd_q.cmd  <= CMD_NOP;
         dq_oe_n_q <= 1'b1;
         case (st_q)
            S_INIT: begin                // power-up pause before any command
               if (cnt_q == 16'h0000) st_q <= S_PALL;
               else cnt_q <= cnt_q - 16'h0001;
            end
            S_PALL: begin
               sd_q.cmd             <= CMD_PALL;
               sd_q.a[`RXD_AP_BIT] <= 1'b1;
               st_q                 <= S_MRS;
            end
            S_MRS: begin                 // burst of one, fixed latency
               sd_q.cmd <= CMD_MRS;
               sd_q.ba  <= 2'h0;
               sd_q.a   <= `RXD_MODE_VAL;
               cnt_q    <= 16'(`RXD_TRC_CYC);
               st_q     <= S_WAIT;
            end
            S_IDLE: begin
               if (fall_p && i_seq.ram_req) begin
                  // address taken at the first low dot edge
                  acc_addr_q <= exp_addr_q;
                  we_q       <= i_seq.ram_we;
                  wr_data_q  <= hdata_s;
                  sd_q.cmd   <= CMD_ACT;
                  sd_q.ba    <= exp_addr_q[25:24];
                  sd_q.a     <= exp_addr_q[23:11];
                  st_q       <= S_RW;
               end else if (phi2_s && !rise_p && cnt_q == 16'h0000) begin
                  cnt_q <= 16'h0000;     // refresh only at the rise, never later in the high half
               end else if (rise_p) begin
                  sd_q.cmd <= CMD_REF;   // refresh in the high half
                  cnt_q    <= 16'(`RXD_TRC_CYC);
                  st_q     <= S_WAIT;
               end
            end
            S_RW: begin
               // auto-precharge so the bank is closed before phi2 rises
               sd_q.cmd <= we_q ? CMD_WR : CMD_RD;
               sd_q.a   <= {1'b0, acc_addr_q[10], 1'b1, acc_addr_q[9:0]};
               if (we_q) begin
                  dq_oe_n_q <= 1'b0;
                  cnt_q     <= 16'(`RXD_TWR_CYC);
               end else begin
                  rd_pend_q <= 1'b1;
                  cnt_q     <= 16'(`RXD_CAS_LAT);
               end
               st_q <= S_WAIT;
            end
            S_WAIT: begin                // latency, recovery or refresh time
               if (cnt_q == 16'h0000) begin
                  if (rd_pend_q) rd_data_q <= i_sdram_dq;
                  rd_pend_q <= 1'b0;
                  st_q      <= S_IDLE;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            default: st_q <= S_INIT;
         endcase
      end
   end
   assign o_sdram         = sd_q;
   assign o_sdram_dq      = wr_data_q;
   assign o_sdram_dq_oe_n = dq_oe_n_q;

   // ----- register block
   logic [7:0]  cmd_q, imask_q, actrl_q;
   logic [15:0] host_addr_q, len_q;      // host_mem_addr and length
   logic [15:0] host_sh_q, len_sh_q;     // autoload shadows
   logic [25:0] exp_sh_q;
   logic        end_q, fault_q;          // sticky status flags
   logic        reg_sel;
   logic        reg_wr, reg_rd;
   logic        adv_ok;
   logic [7:0]  reg_rdata;
   logic        irq_act;

   // one port serves every host register access
   assign reg_sel = ~sel_n_s & ~i_seq.dma;
   assign reg_wr  = fall_p & reg_sel & ~rw_s;   // writes land at the fall
   assign reg_rd  = fall_p & reg_sel & rw_s;
   // strobes count only while the host bus is really ours
   assign adv_ok  = fall_p & i_seq.dma & ba_s;

   // address, length and control registers
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         cmd_q       <= `RXD_RST_BYTE;
         imask_q     <= `RXD_RST_BYTE;
         actrl_q     <= `RXD_RST_BYTE;
         host_addr_q <= 16'h0000;
         host_sh_q   <= 16'h0000;
         exp_addr_q  <= 26'h0000000;
         exp_sh_q    <= 26'h0000000;
         len_q       <= `RXD_RST_LEN;
         len_sh_q    <= `RXD_RST_LEN;
      end else if (i_ce) begin
         if (adv_ok && i_seq.transfer_done && cmd_q[`RXD_CMD_AUTO]) begin
            host_addr_q <= host_sh_q;    // autoload restores the start
            exp_addr_q  <= exp_sh_q;
            len_q       <= len_sh_q;
         end else if (adv_ok) begin
            if (i_seq.expansion_addr_advance && !actrl_q[`RXD_AC_FIXE])
               exp_addr_q <= exp_addr_q + 26'h0000001;
            if (i_seq.host_addr_advance && !actrl_q[`RXD_AC_FIXH])
               host_addr_q <= host_addr_q + 16'h0001;
            if (i_seq.expansion_addr_advance && len_q != 16'h0001)
               len_q <= len_q - 16'h0001;
         end
         if (adv_ok && i_seq.transfer_done) cmd_q[`RXD_CMD_EXEC] <= 1'b0;
         if (reg_wr) begin
            case (haddr_s[4:0])
               `RXD_OFS_CMD:    cmd_q   <= hdata_s;
               `RXD_OFS_IMASK:  imask_q <= hdata_s;
               `RXD_OFS_ACTRL:  actrl_q <= hdata_s;
               `RXD_OFS_HA_LO: begin
                  host_addr_q[7:0] <= hdata_s;
                  host_sh_q[7:0]   <= hdata_s;
               end
               `RXD_OFS_HA_HI: begin
                  host_addr_q[15:8] <= hdata_s;
                  host_sh_q[15:8]   <= hdata_s;
               end
               `RXD_OFS_EA_0: begin
                  exp_addr_q[7:0] <= hdata_s;
                  exp_sh_q[7:0]   <= hdata_s;
               end
               `RXD_OFS_EA_1: begin
                  exp_addr_q[15:8] <= hdata_s;
                  exp_sh_q[15:8]   <= hdata_s;
               end
               `RXD_OFS_EA_2: begin
                  exp_addr_q[23:16] <= hdata_s;
                  exp_sh_q[23:16]   <= hdata_s;
               end
               `RXD_OFS_EA_3: begin
                  exp_addr_q[25:24] <= hdata_s[1:0];
                  exp_sh_q[25:24]   <= hdata_s[1:0];
               end
               `RXD_OFS_LEN_LO: begin
                  len_q[7:0]    <= hdata_s;
                  len_sh_q[7:0] <= hdata_s;
               end
               `RXD_OFS_LEN_HI: begin
                  len_q[15:8]    <= hdata_s;
                  len_sh_q[15:8] <= hdata_s;
               end
               default: ;                // status and holes ignore writes
            endcase
         end
      end
   end

   // sticky end and fault flags; a new event beats the read-clear
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         end_q   <= 1'b0;
         fault_q <= 1'b0;
      end else if (i_ce) begin
         if (adv_ok && i_seq.transfer_done) begin
            end_q <= 1'b1;
            if (i_seq.compare_mismatch) fault_q <= 1'b1;
         end else if (reg_rd && haddr_s[4:0] == `RXD_OFS_STATUS) begin
            end_q   <= 1'b0;
            fault_q <= 1'b0;
         end
      end
   end

   // interrupt only for the sources software enabled
   assign irq_act = imask_q[`RXD_IM_EN] &
                    ((end_q & imask_q[`RXD_IM_END]) | (fault_q & imask_q[`RXD_IM_FAULT]));

   // register read mux
   always_comb begin
      reg_rdata = 8'h00;
      case (haddr_s[4:0])
         `RXD_OFS_STATUS: reg_rdata = {irq_act, end_q, fault_q, 5'h00};
         `RXD_OFS_CMD:    reg_rdata = cmd_q;
         `RXD_OFS_HA_LO:  reg_rdata = host_addr_q[7:0];
         `RXD_OFS_HA_HI:  reg_rdata = host_addr_q[15:8];
         `RXD_OFS_EA_0:   reg_rdata = exp_addr_q[7:0];
         `RXD_OFS_EA_1:   reg_rdata = exp_addr_q[15:8];
         `RXD_OFS_EA_2:   reg_rdata = exp_addr_q[23:16];
         `RXD_OFS_EA_3:   reg_rdata = {6'h00, exp_addr_q[25:24]};
         `RXD_OFS_LEN_LO: reg_rdata = len_q[7:0];
         `RXD_OFS_LEN_HI: reg_rdata = len_q[15:8];
         `RXD_OFS_IMASK:  reg_rdata = imask_q;
         `RXD_OFS_ACTRL:  reg_rdata = actrl_q;
         default:         reg_rdata = 8'h00;
      endcase
   end

   // ----- datapath, address buffer and glue
   logic [7:0] hout_q;
   logic       irq_q;

   // data mux registered: sdram byte in dma, registers otherwise
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         hout_q <= 8'h00;
         irq_q  <= 1'b0;
      end else if (i_ce) begin
         hout_q <= i_seq.dma ? rd_data_q : reg_rdata;
         irq_q  <= irq_act;
      end
   end
   assign o_host_data = hout_q;
   assign o_irq       = irq_q;

   // expansion address reaches sdram, host address reaches the bus
   assign o_host_addr      = host_addr_q;
   assign o_host_addr_oe_n = ~i_seq.dma;
   // drive the host data bus on register reads or dma toward host
   assign o_host_data_oe_n = ~((reg_sel & rw_s & phi2_s) | (i_seq.dma & ~i_seq.ram_we & ba_s));
   assign o_buf_dir        = ~o_host_data_oe_n;
   assign o_dma_n          = ~i_seq.dma;

   // status toward the sequencer; length stays inside
   assign o_stat.exec       = cmd_q[`RXD_CMD_EXEC];
   assign o_stat.xfer_type  = cmd_q[1:0];
   assign o_stat.len_is_one = (len_q == 16'h0001);
   assign o_stat.match      = (rd_data_q == hdata_s);
   assign o_stat.ram_busy   = (st_q != S_IDLE);
endmodule : rxd_core
`default_nettype wire

// ==== verilog/rxd_defines.svh ====
// offsets, field positions, reset values and timing counts of the expansion core
// assumes a 10 MHz dot clock and an 8-bit register port addressed by the low host bits
`ifndef RXD_DEFINES_SVH
`define RXD_DEFINES_SVH
`define RXD_CLK_NS      100
`define RXD_INIT_NS     100000
`define RXD_INIT_CYC    ((`RXD_INIT_NS + `RXD_CLK_NS - 1) / `RXD_CLK_NS)
`define RXD_TRC_NS      70
`define RXD_TRC_CYC     ((`RXD_TRC_NS + `RXD_CLK_NS - 1) / `RXD_CLK_NS)
`define RXD_TWR_NS      20
`define RXD_TWR_CYC     ((`RXD_TWR_NS + `RXD_CLK_NS - 1) / `RXD_CLK_NS)
`define RXD_CAS_LAT     2
`define RXD_MODE_VAL    13'h0020
`define RXD_AP_BIT      10
`define RXD_OFS_STATUS  5'h00
`define RXD_OFS_CMD     5'h01
`define RXD_OFS_HA_LO   5'h02
`define RXD_OFS_HA_HI   5'h03
`define RXD_OFS_EA_0    5'h04
`define RXD_OFS_EA_1    5'h05
`define RXD_OFS_EA_2    5'h06
`define RXD_OFS_EA_3    5'h07
`define RXD_OFS_LEN_LO  5'h08
`define RXD_OFS_LEN_HI  5'h09
`define RXD_OFS_IMASK   5'h0A
`define RXD_OFS_ACTRL   5'h0B
`define RXD_ST_IRQ      7
`define RXD_ST_END      6
`define RXD_ST_FAULT    5
`define RXD_CMD_EXEC    7
`define RXD_CMD_AUTO    5
`define RXD_IM_EN       7
`define RXD_IM_END      6
`define RXD_IM_FAULT    5
`define RXD_AC_FIXH     7
`define RXD_AC_FIXE     6
`define RXD_RST_BYTE    8'h00
`define RXD_RST_LEN     16'hFFFF
`endif

// ==== verilog/rxd_pkg.sv ====
// types shared by the expansion core and its surroundings
// assumes the sequencer sits outside on the same dot clock
package rxd_pkg;
   typedef enum logic [3:0] {
      CMD_NOP  = 4'h7,
      CMD_ACT  = 4'h3,
      CMD_RD   = 4'h5,
      CMD_WR   = 4'h4,
      CMD_PALL = 4'h2,
      CMD_REF  = 4'h1,
      CMD_MRS  = 4'h0
   } rxd_cmd_t;                          // {cs_n, ras_n, cas_n, we_n}
   typedef enum {S_INIT, S_PALL, S_MRS, S_IDLE, S_RW, S_WAIT} rxd_state_t;
   typedef struct packed {
      rxd_cmd_t    cmd;
      logic [1:0]  ba;
      logic [12:0] a;
   } rxd_sdram_t;
   typedef struct packed {
      logic dma;                         // sequencer owns the host bus
      logic ram_req;                     // access wanted this low half
      logic ram_we;                      // access is a write
      logic expansion_addr_advance;
      logic host_addr_advance;
      logic transfer_done;
      logic compare_mismatch;
   } rxd_seq_t;
   typedef struct packed {
      logic       exec;                  // transfer requested by software
      logic [1:0] xfer_type;
      logic       len_is_one;
      logic       match;
      logic       ram_busy;
   } rxd_stat_t;
endpackage : rxd_pkg
